/* File: src/cax_execute.sv */
// Function
// - Add two registers, optionally with carry, write back and update Z C N V H in one cycle.
// - Subtract source from destination, maybe with borrow, store, update Z C N V H in one cycle.
// - Subtract a constant, with or without borrow, store and update Z C N V H in one cycle.
// - AND with register or constant is written back updating only Z N V S in one cycle.
// - OR with register or constant, including set bits, is written back updating Z N V.
// - Clear bits ANDs with all ones minus the mask, stores and updates Z N V.
// - Test ANDs the register with itself, keeps it and sets Z N V.
// - Equal compare skips the next instruction by 2 or 3, 1 or 2 cycles, no flags.
// - Compare immediate takes destination minus constant, stores nothing, updates Z N V C H.
// - Bit-low skip advances by 2 or 3 when the chosen bit is zero, no flags.
`timescale 1ns/1ns
`default_nettype none
module cax_execute
	import cax_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Instruction from the decoder
	input wire logic issue,
	input wire cax_op_e opCode,
	input wire logic bitSkip,
	input wire logic [7:0] destVal,
	input wire logic [7:0] sourceReg,
	input wire logic [7:0] immVal,
	input wire logic [2:0] bitSel,
	input wire logic nextIsLong,
	input wire logic [PC_W-1:0] pcIn,
	// Register file write back
	output logic wrEn_r,
	output logic [7:0] wrData_r,
	// Program counter update
	output logic pcLoad_r,
	output logic [PC_W-1:0] pcNext_r,
	// Status and timing
	output logic [FLG_W-1:0] flags_r,
	output logic busy_r,
	output logic done_r
);
	logic [7:0] aluB;
	logic aluCin;
	logic aluSub;
	logic [7:0] aluRes;
	logic aluC;
	logic aluH;
	logic aluV;
	logic [7:0] logicRes;
	logic arith;
	logic logical;
	logic store;
	logic skipTake;
	logic [FLG_W-1:0] flags_nxt;
	cax_skip_e skip_r;
	logic [1:0] cycCount;

	function automatic logic signFlag(input logic n, input logic v);
		signFlag = n ^ v;
	endfunction

	// ==========================================
	// Operand select
	always_comb begin
		aluB = sourceReg;
		aluCin = 1'b0;
		aluSub = 1'b0;
		arith = 1'b0;
		store = 1'b1;
		case (opCode)
			OP_ADD: begin
				arith = 1'b1;
			end
			OP_ADD_CARRY: begin
				arith = 1'b1;
				aluCin = flags_r[FLG_C];
			end
			OP_SUB: begin
				arith = 1'b1;
				aluSub = 1'b1;
			end
			OP_DIFFERENCE_WITH_BORROW: begin
				arith = 1'b1;
				aluSub = 1'b1;
				aluCin = flags_r[FLG_C];
			end
			OP_DIFFERENCE_IMMEDIATE: begin
				arith = 1'b1;
				aluSub = 1'b1;
				aluB = immVal;
			end
			OP_DIFFERENCE_IMMEDIATE_BORROW: begin
				arith = 1'b1;
				aluSub = 1'b1;
				aluB = immVal;
				aluCin = flags_r[FLG_C];
			end
			OP_COMPARE_IMMEDIATE: begin
				arith = 1'b1;
				aluSub = 1'b1;
				aluB = immVal;
				store = 1'b0;
			end
			OP_EQUAL_SKIP: begin
				store = 1'b0;
			end
			OP_NONE: begin
				store = 1'b0;
			end
			default: begin
				arith = 1'b0;
			end
		endcase
		if (bitSkip) begin
			store = 1'b0;
			arith = 1'b0;
		end
	end

	cax_arith u_arith (
		.opA(destVal),
		.opB(aluB),
		.carryIn(aluCin),
		.doSub(aluSub),
		.result(aluRes),
		.carryOut(aluC),
		.halfOut(aluH),
		.overOut(aluV)
	);

	// ==========================================
	// Logic unit
	always_comb begin
		logical = ~bitSkip;
		case (opCode)
			OP_AND: logicRes = destVal & sourceReg;
			OP_MASK_WITH_CONSTANT: logicRes = destVal & immVal;
			OP_OR: logicRes = destVal | sourceReg;
			OP_MERGE_WITH_CONSTANT, OP_SET_BITS_IMMEDIATE: logicRes = destVal | immVal;
			OP_CLEAR_BITS_IMMEDIATE: logicRes = destVal & (ALL_ONES - immVal);
			OP_ZERO_SIGN_CHECK: logicRes = destVal & destVal;
			default: begin
				logicRes = ZERO_BYTE;
				logical = 1'b0;
			end
		endcase
	end

	always_comb begin
		flags_nxt = flags_r;
		if (arith) begin
			flags_nxt[FLG_C] = aluC;
			flags_nxt[FLG_H] = aluH;
			flags_nxt[FLG_V] = aluV;
			flags_nxt[FLG_N] = aluRes[7];
			flags_nxt[FLG_Z] = (aluRes == ZERO_BYTE);
			flags_nxt[FLG_S] = signFlag(aluRes[7], aluV);
		end else if (logical) begin
			flags_nxt[FLG_V] = 1'b0;
			flags_nxt[FLG_N] = logicRes[7];
			flags_nxt[FLG_Z] = (logicRes == ZERO_BYTE);
			flags_nxt[FLG_S] = signFlag(logicRes[7], 1'b0);
		end
	end

	assign skipTake = bitSkip ? ~sourceReg[bitSel] :
		(opCode == OP_EQUAL_SKIP) && (destVal == sourceReg);

	// ==========================================
	// Result and flag registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wrEn_r <= 1'b0;
			wrData_r <= ZERO_BYTE;
			flags_r <= FLAGS_RST;
		end else begin
			wrEn_r <= issue && !busy_r && store;
			if (issue && !busy_r) begin
				wrData_r <= arith ? aluRes : logicRes;
				flags_r <= flags_nxt;
			end
		end
	end

	// Program counter and skip timing
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pcLoad_r <= 1'b0;
			pcNext_r <= '0;
			skip_r <= SK_IDLE;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			cycCount <= '0;
		end else begin
			pcLoad_r <= 1'b0;
			done_r <= 1'b0;
			case (skip_r)
				SK_IDLE: begin
					if (issue) begin
						pcLoad_r <= 1'b1;
						if (skipTake) begin
							pcNext_r <= pcIn + (nextIsLong ? PC_STEP_THREE : PC_STEP_TWO);
							skip_r <= SK_SKIP;
							busy_r <= 1'b1;
							cycCount <= CYC_TWO;
						end else begin
							pcNext_r <= pcIn + PC_STEP_ONE;
							done_r <= 1'b1;
							cycCount <= CYC_ONE;
						end
					end
				end
				SK_SKIP: begin
					skip_r <= SK_IDLE;
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
				default: skip_r <= SK_IDLE;
			endcase
		end
	end

	// ==========================================
	// Checks
	property p_skip_two;
		@(posedge clk) disable iff (reset)
		issue && !busy_r && skipTake |=> busy_r && cycCount == CYC_TWO ##1 (done_r && !busy_r);
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");
	property p_one_cycle;
		@(posedge clk) disable iff (reset)
		issue && !busy_r && !skipTake |=> done_r && !busy_r && cycCount == CYC_ONE;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("not one cycle");
	property p_skip_pc;
		@(posedge clk) disable iff (reset)
		issue && !busy_r && skipTake && !nextIsLong |=> pcNext_r == $past(pcIn) + PC_STEP_TWO;
	endproperty
	a_skip_pc: assert property (p_skip_pc) else $error("skip pc wrong");
	property p_skip_flags;
		@(posedge clk) disable iff (reset)
		issue && !busy_r && (bitSkip || opCode == OP_EQUAL_SKIP) |=> $stable(flags_r);
	endproperty
	a_skip_flags: assert property (p_skip_flags) else $error("skip changed flags");
	property p_cmp_nostore;
		@(posedge clk) disable iff (reset)
		issue && !busy_r && !bitSkip && opCode == OP_COMPARE_IMMEDIATE |=> !wrEn_r;
	endproperty
	a_cmp_nostore: assert property (p_cmp_nostore) else $error("compare stored");
	property p_logic_carry;
		@(posedge clk) disable iff (reset)
		issue && !busy_r && logical |=> $stable(flags_r[FLG_C]) && !flags_r[FLG_V];
	endproperty
	a_logic_carry: assert property (p_logic_carry) else $error("logic flags wrong");
	property p_clear_bits;
		@(posedge clk) disable iff (reset)
		issue && !busy_r && !bitSkip && opCode == OP_CLEAR_BITS_IMMEDIATE
		|=> (wrData_r & $past(immVal)) == ZERO_BYTE;
	endproperty
	a_clear_bits: assert property (p_clear_bits) else $error("clear bits left set");
	property p_test_keep;
		@(posedge clk) disable iff (reset)
		issue && !busy_r && !bitSkip && opCode == OP_ZERO_SIGN_CHECK
		|=> wrData_r == $past(destVal) && flags_r[FLG_Z] == (wrData_r == ZERO_BYTE);
	endproperty
	a_test_keep: assert property (p_test_keep) else $error("test altered value");
	property p_sub_zero;
		@(posedge clk) disable iff (reset)
		issue && !busy_r && !bitSkip && opCode == OP_SUB
		|=> flags_r[FLG_Z] == ($past(destVal) == $past(sourceReg));
	endproperty
	a_sub_zero: assert property (p_sub_zero) else $error("sub zero flag wrong");
	c_skip: cover property (@(posedge clk) disable iff (reset) issue && skipTake);
	c_add: cover property (@(posedge clk) disable iff (reset) issue && opCode == OP_ADD_CARRY);
	c_cmp: cover property (@(posedge clk) disable iff (reset)
		issue && opCode == OP_COMPARE_IMMEDIATE);
endmodule
`default_nettype wire

/* File: src/cax_pkg.sv */
package cax_pkg;
	// ==========================================
	// Widths and constants
	localparam int DATA_W = 8;
	localparam int PC_W = 16;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
	localparam logic [PC_W-1:0] PC_STEP_TWO = 16'h0002;
	localparam logic [PC_W-1:0] PC_STEP_THREE = 16'h0003;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	// Flag bit positions in the flag vector
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_W = 6;
	localparam logic [FLG_W-1:0] FLAGS_RST = 6'h00;
	// ==========================================
	// Operation codes from the decoder
	typedef enum logic [3:0] {
		OP_NONE,
		OP_ADD,
		OP_ADD_CARRY,
		OP_SUB,
		OP_DIFFERENCE_WITH_BORROW,
		OP_DIFFERENCE_IMMEDIATE,
		OP_DIFFERENCE_IMMEDIATE_BORROW,
		OP_AND,
		OP_MASK_WITH_CONSTANT,
		OP_OR,
		OP_MERGE_WITH_CONSTANT,
		OP_SET_BITS_IMMEDIATE,
		OP_CLEAR_BITS_IMMEDIATE,
		OP_ZERO_SIGN_CHECK,
		OP_EQUAL_SKIP,
		OP_COMPARE_IMMEDIATE
	} cax_op_e;
	typedef enum logic [0:0] {
		SK_IDLE,
		SK_SKIP
	} cax_skip_e;
endpackage

/* File: src/cax_arith.sv */
`timescale 1ns/1ns
`default_nettype none
module cax_arith
	import cax_pkg::*;
(
	// Operands
	input wire logic [7:0] opA,
	input wire logic [7:0] opB,
	input wire logic carryIn,
	input wire logic doSub,
	// Result
	output logic [7:0] result,
	output logic carryOut,
	output logic halfOut,
	output logic overOut
);
	logic [8:0] wide;
	logic [4:0] low;
	// Eight-bit add or subtract, carry reported apart from the byte
	always_comb begin
		if (doSub) begin
			wide = {1'b0, opA} - {1'b0, opB} - {8'h00, carryIn};
			low = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, carryIn};
		end else begin
			wide = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
			low = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
		end
		result = wide[7:0];
		carryOut = wide[8];
		halfOut = low[4];
		if (doSub) begin
			overOut = (opA[7] & ~opB[7] & ~wide[7]) | (~opA[7] & opB[7] & wide[7]);
		end else begin
			overOut = (opA[7] & opB[7] & ~wide[7]) | (~opA[7] & ~opB[7] & wide[7]);
		end
	end
endmodule
`default_nettype wire

/* File: verif/cax_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cax_core_model
	import cax_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Write back and program counter load
	input wire logic wrEn,
	input wire logic [7:0] wrData,
	input wire logic pcLoad,
	input wire logic [PC_W-1:0] pcNext,
	// Stored register and forwarded counter
	output logic [7:0] regVal,
	output logic [PC_W-1:0] pcVal
);
	logic [7:0] destReg_r;
	logic [PC_W-1:0] pc_r;

	// ==========================================
	// Register file slot and program counter
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			destReg_r <= ZERO_BYTE;
			pc_r <= 16'h0000;
		end else begin
			if (wrEn) destReg_r <= wrData;
			if (pcLoad) pc_r <= pcNext;
		end
	end

	// Counter forwarded so back to back issue sees the new value
	assign regVal = destReg_r;
	assign pcVal = pcLoad ? pcNext : pc_r;
endmodule
`default_nettype wire

/* File: verif/test_core_alu_compare_skip_execute.sv */
`timescale 1ns/1ns
`default_nettype none
module test_core_alu_compare_skip_execute import cax_pkg::*;;
	logic clk, reset, issue, bitSkip, nextIsLong, wrEn, pcLoad, busy, done;
	cax_op_e opCode;
	logic [7:0] destVal, sourceReg, immVal, wrData, regVal, expReg;
	logic [2:0] bitSel;
	logic [PC_W-1:0] pcIn, pcNext, expPc;
	logic [FLG_W-1:0] flags, expFlags;
	int err_total, num_checks;

	// ==========================================
	// Design and far side
	cax_execute dut_u (.clk(clk), .reset(reset), .issue(issue), .opCode(opCode),
		.bitSkip(bitSkip), .destVal(destVal), .sourceReg(sourceReg), .immVal(immVal),
		.bitSel(bitSel), .nextIsLong(nextIsLong), .pcIn(pcIn), .wrEn_r(wrEn),
		.wrData_r(wrData), .pcLoad_r(pcLoad), .pcNext_r(pcNext), .flags_r(flags),
		.busy_r(busy), .done_r(done));
	cax_core_model model_u (.clk(clk), .reset(reset), .wrEn(wrEn), .wrData(wrData),
		.pcLoad(pcLoad), .pcNext(pcNext), .regVal(regVal), .pcVal(pcIn));

	// Clock generation
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task print_verdict;
		if (err_total == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Expected write, result and flags
	function automatic logic [14:0] calc(cax_op_e op, logic [7:0] d, s, k, logic [5:0] f);
		logic [8:0] t;
		logic [4:0] n;
		logic [7:0] b, r;
		logic c, sb, ar, wr;
		b = s;
		c = 1'b0;
		sb = 1'b0;
		ar = 1'b1;
		wr = 1'b1;
		r = d;
		case (op)
			OP_ADD_CARRY: c = f[FLG_C];
			OP_SUB: sb = 1'b1;
			OP_DIFFERENCE_WITH_BORROW: {sb, c} = {1'b1, f[FLG_C]};
			OP_DIFFERENCE_IMMEDIATE: {sb, b} = {1'b1, k};
			OP_DIFFERENCE_IMMEDIATE_BORROW: {sb, b, c} = {1'b1, k, f[FLG_C]};
			OP_COMPARE_IMMEDIATE: {sb, b, wr} = {1'b1, k, 1'b0};
			OP_AND: {ar, r} = {1'b0, d & s};
			OP_MASK_WITH_CONSTANT: {ar, r} = {1'b0, d & k};
			OP_OR: {ar, r} = {1'b0, d | s};
			OP_MERGE_WITH_CONSTANT, OP_SET_BITS_IMMEDIATE: {ar, r} = {1'b0, d | k};
			OP_CLEAR_BITS_IMMEDIATE: {ar, r} = {1'b0, d & (ALL_ONES - k)};
			OP_ZERO_SIGN_CHECK: ar = 1'b0;
			OP_NONE, OP_EQUAL_SKIP: return {1'b0, d, f};
			default: ;
		endcase
		if (ar) begin
			t = sb ? {1'b0, d} - {1'b0, b} - 9'(c) : {1'b0, d} + {1'b0, b} + 9'(c);
			n = sb ? {1'b0, d[3:0]} - {1'b0, b[3:0]} - 5'(c) : {1'b0, d[3:0]} + b[3:0] + 5'(c);
			r = t[7:0];
			f[FLG_C] = t[8];
			f[FLG_H] = n[4];
			f[FLG_V] = (sb ? d[7] ^ b[7] : ~(d[7] ^ b[7])) & (d[7] ^ r[7]);
		end else f[FLG_V] = 1'b0;
		f[FLG_Z] = (r == ZERO_BYTE);
		f[FLG_N] = r[7];
		f[FLG_S] = f[FLG_N] ^ f[FLG_V];
		return {wr, r, f};
	endfunction

	// One instruction, with a refused issue in the dead cycle of a skip
	task automatic run(cax_op_e op, logic bs, logic [7:0] d, s, k, logic [2:0] b, logic lg);
		logic [14:0] e;
		logic sk;
		e = calc(op, d, s, k, expFlags);
		sk = bs ? !s[b] : (op == OP_EQUAL_SKIP && d == s);
		if (bs) e = {1'b0, d, expFlags};
		expPc = expPc + (sk ? (lg ? PC_STEP_THREE : PC_STEP_TWO) : PC_STEP_ONE);
		opCode = op;
		{bitSkip, destVal, sourceReg, immVal, bitSel, nextIsLong, issue} = {bs, d, s, k, b, lg, 1'b1};
		@(posedge clk);
		#1;
		// Issue stays up: refused in a skip's dead cycle, next instruction otherwise
		if (sk) opCode = OP_ADD;
		chk(regVal, expReg);
		chk(wrEn, e[14]);
		if (e[14]) chk(wrData, e[13:6]);
		chk(flags, e[5:0]);
		chk(pcLoad, 1'b1);
		chk(pcNext, expPc);
		chk({done, busy}, {!sk, sk});
		if (e[14]) expReg = e[13:6];
		expFlags = e[5:0];
		if (sk) begin
			@(posedge clk);
			#1;
			chk({busy, done, wrEn, pcLoad}, 4'h4);
			chk(pcIn, expPc);
		end
	endtask

	// Watchdog
	initial begin
		#40000;
		err_total++;
		print_verdict;
	end

	// Main sequence
	initial begin
		{bitSkip, destVal, sourceReg, immVal, bitSel, nextIsLong, issue} = 30'h0;
		opCode = OP_ADD;
		reset = 1'b1;
		err_total = 0;
		num_checks = 0;
		expFlags = FLAGS_RST;
		expPc = 16'h0000;
		expReg = ZERO_BYTE;
		void'($urandom(41294));
		repeat (10) @(posedge clk);
		#1;
		reset = 1'b0;
		chk({wrEn, pcLoad, done, busy, flags}, 16'h0000);
		run(OP_ADD, 1'b0, 8'hFF, 8'h01, 8'h00, 3'h0, 1'b0);
		run(OP_ADD_CARRY, 1'b0, 8'h0F, 8'h70, 8'h00, 3'h0, 1'b0);
		run(OP_SUB, 1'b0, 8'h80, 8'h01, 8'h00, 3'h0, 1'b0);
		run(OP_DIFFERENCE_IMMEDIATE_BORROW, 1'b0, 8'h00, 8'h00, 8'h01, 3'h0, 1'b0);
		run(OP_DIFFERENCE_WITH_BORROW, 1'b0, 8'h10, 8'h0F, 8'h00, 3'h0, 1'b0);
		run(OP_CLEAR_BITS_IMMEDIATE, 1'b0, 8'hA5, 8'h00, 8'hFF, 3'h0, 1'b0);
		run(OP_ZERO_SIGN_CHECK, 1'b0, 8'h80, 8'h00, 8'h00, 3'h0, 1'b0);
		run(OP_EQUAL_SKIP, 1'b0, 8'h3C, 8'h3C, 8'h00, 3'h0, 1'b1);
		run(OP_EQUAL_SKIP, 1'b0, 8'h3C, 8'h3D, 8'h00, 3'h0, 1'b1);
		run(OP_COMPARE_IMMEDIATE, 1'b0, 8'h10, 8'h00, 8'h10, 3'h0, 1'b0);
		run(OP_ADD, 1'b1, 8'h00, 8'h7F, 8'h00, 3'h7, 1'b0);
		run(OP_ADD, 1'b1, 8'h00, 8'h80, 8'h00, 3'h7, 1'b1);
		run(OP_NONE, 1'b0, 8'h55, 8'h55, 8'hAA, 3'h0, 1'b0);
		for (int i = 0; i < 600; i++) begin
			run(cax_op_e'(4'(i % 15 + 1)), ($urandom % 5) == 0, 8'($urandom), 8'($urandom),
				8'($urandom), 3'($urandom), 1'($urandom));
		end
		print_verdict;
	end
endmodule
`default_nettype wire
